/* incfind_pkg.sv */
// package for the increment / find-bit unit: opcodes, widths, latencies
// assumes nothing of its surroundings
package incfind_pkg;
    localparam int unsigned REG_WIDTH = 64;
    localparam int unsigned CHUNK_WIDTH = 8;
    localparam int unsigned OP_WIDTH = 4;
    localparam logic [3:0] OP_INC = 4'h0;
    localparam logic [3:0] OP_DEC = 4'h1;
    localparam logic [3:0] OP_NEG = 4'h2;
    localparam logic [3:0] OP_ABS = 4'h3;
    localparam logic [3:0] OP_LOWEST_SET = 4'h4;
    localparam logic [3:0] OP_LOWEST_CLEAR = 4'h5;
    localparam logic [3:0] OP_HIGHEST_SET = 4'h6;
    localparam logic [3:0] OP_HIGHEST_CLEAR = 4'h7;
    localparam logic [3:0] OP_MIN = 4'h8;
    localparam logic [3:0] OP_MAX = 4'h9;
    localparam logic [3:0] OP_CLIP = 4'ha;
    localparam logic [3:0] OP_CMP = 4'hb;
    localparam int unsigned LAT_SHORT = 1;
    localparam int unsigned LAT_LONG = 2;
    localparam logic RESET_VALID = 1'b0;
endpackage

/* incfind_chunk.sv */
// one chunk of the increment / find-first-bit tree, purely combinational
// assumes the caller cuts carries at chunk edges by instancing one per chunk
`timescale 1ns/1ns
`default_nettype none
module incfind_chunk #(
    parameter int unsigned W = 8
) (
    input wire logic [W-1:0] opnd,   // operand bits for this chunk
    input wire logic inv,            // invert input and output
    output logic [W-1:0] flip_mask,  // bits from lsb through first zero
    output logic [W-1:0] inc_out,    // incremented (or decremented) value
    output logic [W-1:0] first_one   // one-hot first zero of x, lowest one when inv
);
    logic [W-1:0] x;
    logic [W-1:0] ones_below;
    always_comb begin
        x = opnd ^ {W{inv}};
        ones_below[0] = 1'b1;
        for (int i = 1; i < W; i++) begin
            ones_below[i] = ones_below[i-1] & x[i-1];
        end
        flip_mask = ones_below;
        inc_out = (x ^ flip_mask) ^ {W{inv}};
        first_one = ones_below & ~x;
    end
endmodule // incfind_chunk
`default_nettype wire

/* incfind_unit.sv */
// increment / find-bit execution unit, top module
// assumes operands and opcode valid for one cycle with IN_VALID
`timescale 1ns/1ns
`default_nettype none
module incfind_unit #(
    parameter int unsigned RW = incfind_pkg::REG_WIDTH,
    parameter int unsigned CW = incfind_pkg::CHUNK_WIDTH
) (
    input wire logic CLOCK,                       // core clock
    input wire logic RST_N,                       // async reset, active low
    input wire logic IN_VALID,                    // operands present
    input wire logic [3:0] IN_OP,                 // operation code
    input wire logic IN_SIMD,                     // 1: per chunk, 0: whole word
    input wire logic IN_SIGNED,                   // signed compare
    input wire logic [RW-1:0] IN_A,               // first operand
    input wire logic [RW-1:0] IN_B,               // second operand
    output logic OUT_VALID,                       // result valid pulse
    output logic [RW-1:0] OUT_RESULT              // result word
);
    localparam int unsigned NC = RW / CW;

    typedef struct packed {
        logic s1_valid;
        logic s1_long;
        logic [3:0] s1_op;
        logic s1_simd;
        logic [RW-1:0] s1_a;
        logic [RW-1:0] s1_b;
        logic [RW-1:0] s1_x;
        logic out_valid;
        logic [RW-1:0] out_result;
    } state_t;

    state_t st_q;
    state_t st_d;

    // lane bit reversal: chunk-local in simd, whole word otherwise
    function automatic logic [RW-1:0] rev_lanes(input logic [RW-1:0] v, input logic simd);
        logic [RW-1:0] r;
        r = '0;
        for (int i = 0; i < RW; i++) begin
            if (simd) begin
                r[(i / CW) * CW + (CW - 1 - (i % CW))] = v[i];
            end else begin
                r[RW - 1 - i] = v[i];
            end
        end
        return r;
    endfunction

    // whole-word or chunked lowest-set one-hot helper
    function automatic logic [RW-1:0] low_one(input logic [RW-1:0] v, input logic simd);
        logic [RW-1:0] r;
        logic seen;
        r = '0;
        seen = 1'b0;
        for (int i = 0; i < RW; i++) begin
            if (simd && (i % CW) == 0) begin
                seen = 1'b0;
            end
            r[i] = v[i] & ~seen;
            seen = seen | v[i];
        end
        return r;
    endfunction

    function automatic logic [RW-1:0] onehot_idx(input logic [RW-1:0] h, input logic simd);
        logic [RW-1:0] r;
        r = '0;
        for (int i = 0; i < RW; i++) begin
            if (h[i]) begin
                if (simd) begin
                    r[(i / CW) * CW +: CW] = CW'(i % CW);
                end else begin
                    r = RW'(i);
                end
            end
        end
        return r;
    endfunction

    logic [RW-1:0] a_word;
    logic inv_sel;
    logic [RW-1:0] chunk_inc;

    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : g_chunk
            incfind_chunk #(.W(CW)) u_chunk (
                .opnd(a_word[g*CW +: CW]),
                .inv(inv_sel),
                .flip_mask(),
                .inc_out(chunk_inc[g*CW +: CW]),
                .first_one()
            );
        end
    endgenerate

    logic [RW-1:0] sign_mask;
    always_comb begin
        sign_mask = '0;
        for (int i = 0; i < NC; i++) begin
            sign_mask[i*CW + CW - 1] = 1'b1;
        end
    end

    logic [RW-1:0] neg_a;
    logic [RW-1:0] abs_a;
    logic [RW-1:0] inc_a;
    logic [RW-1:0] dec_a;
    logic [RW-1:0] word_sign;

    always_comb begin
        a_word = IN_A;
        inv_sel = (IN_OP == incfind_pkg::OP_DEC);
        inc_a = IN_SIMD ? chunk_inc : IN_A + RW'(1);
        dec_a = IN_SIMD ? chunk_inc : IN_A - RW'(1);
        // negate is increment of inverted operand
        neg_a = IN_SIMD ? '0 : (~IN_A) + RW'(1);
        for (int c = 0; c < NC; c++) begin
            if (IN_SIMD) begin
                neg_a[c*CW +: CW] = (~IN_A[c*CW +: CW]) + CW'(1);
            end
        end
        abs_a = IN_A[RW-1] ? neg_a : IN_A;
        for (int c = 0; c < NC; c++) begin
            if (IN_SIMD) begin
                abs_a[c*CW +: CW] = IN_A[c*CW + CW - 1] ? neg_a[c*CW +: CW] : IN_A[c*CW +: CW];
            end
        end
        word_sign = IN_SIMD ? sign_mask : {1'b1, {(RW-1){1'b0}}};
    end

    // stage-two work on registered operands
    logic [RW-1:0] s2_find;
    logic [RW-1:0] s2_sel;
    logic [RW-1:0] ka;
    logic [RW-1:0] kb;
    logic [RW-1:0] top_diff;
    logic [RW-1:0] a_gt;
    always_comb begin
        s2_find = '0;
        ka = st_q.s1_a ^ (st_q.s1_x);
        kb = st_q.s1_b ^ (st_q.s1_x);
        top_diff = rev_lanes(low_one(rev_lanes(ka ^ kb, st_q.s1_simd), st_q.s1_simd),
                             st_q.s1_simd);
        a_gt = '0;
        for (int c = 0; c < NC; c++) begin
            if (st_q.s1_simd) begin
                a_gt[c*CW +: CW] = {CW{|(top_diff[c*CW +: CW] & ka[c*CW +: CW])}};
            end
        end
        if (!st_q.s1_simd) begin
            a_gt = {RW{|(top_diff & ka)}};
        end
        case (st_q.s1_op)
            incfind_pkg::OP_MIN: s2_sel = (a_gt & st_q.s1_b) | (~a_gt & st_q.s1_a);
            incfind_pkg::OP_MAX: s2_sel = (a_gt & st_q.s1_a) | (~a_gt & st_q.s1_b);
            incfind_pkg::OP_CLIP: s2_sel = (a_gt & st_q.s1_b) | (~a_gt & st_q.s1_a);
            incfind_pkg::OP_CMP: s2_sel = a_gt;
            default: s2_sel = st_q.s1_a;
        endcase
        case (st_q.s1_op)
            incfind_pkg::OP_LOWEST_SET:
                s2_find = onehot_idx(low_one(st_q.s1_a, st_q.s1_simd), st_q.s1_simd);
            incfind_pkg::OP_LOWEST_CLEAR:
                s2_find = onehot_idx(low_one(~st_q.s1_a, st_q.s1_simd), st_q.s1_simd);
            incfind_pkg::OP_HIGHEST_SET:
                s2_find = onehot_idx(rev_lanes(low_one(rev_lanes(st_q.s1_a, st_q.s1_simd),
                    st_q.s1_simd), st_q.s1_simd), st_q.s1_simd);
            incfind_pkg::OP_HIGHEST_CLEAR:
                s2_find = onehot_idx(rev_lanes(low_one(rev_lanes(~st_q.s1_a, st_q.s1_simd),
                    st_q.s1_simd), st_q.s1_simd), st_q.s1_simd);
            default: s2_find = s2_sel;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.s1_valid = 1'b0;
        st_d.out_valid = 1'b0;
        // long ops finish in stage two
        if (st_q.s1_valid && st_q.s1_long) begin
            st_d.out_valid = 1'b1;
            st_d.out_result = s2_find;
        end
        if (IN_VALID) begin
            case (IN_OP)
                incfind_pkg::OP_INC: begin
                    st_d.out_valid = 1'b1;
                    st_d.out_result = inc_a;
                end
                incfind_pkg::OP_DEC: begin
                    st_d.out_valid = 1'b1;
                    st_d.out_result = dec_a;
                end
                incfind_pkg::OP_NEG: begin
                    st_d.out_valid = 1'b1;
                    st_d.out_result = neg_a;
                end
                incfind_pkg::OP_ABS: begin
                    st_d.out_valid = 1'b1;
                    st_d.out_result = abs_a;
                end
                default: begin
                    st_d.s1_valid = 1'b1;
                    st_d.s1_long = 1'b1;
                end
            endcase
            st_d.s1_op = IN_OP;
            st_d.s1_simd = IN_SIMD;
            st_d.s1_a = IN_A;
            st_d.s1_b = IN_B;
            st_d.s1_x = IN_SIGNED ? word_sign : '0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign OUT_VALID = st_q.out_valid;
    assign OUT_RESULT = st_q.out_result;

    // long op result exactly two clocks later
    sequence s_long_issue;
        IN_VALID && IN_OP >= incfind_pkg::OP_LOWEST_SET;
    endsequence
    a_long_latency: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_long_issue |-> ##2 OUT_VALID) else $error("long op result missing");
    a_short_latency: assert property (@(posedge CLOCK) disable iff (!RST_N)
        IN_VALID && IN_OP == incfind_pkg::OP_INC |=> OUT_VALID) else $error("inc late");
    a_inc_value: assert property (@(posedge CLOCK) disable iff (!RST_N)
        IN_VALID && !IN_SIMD && IN_OP == incfind_pkg::OP_INC
        |=> OUT_RESULT == $past(IN_A) + RW'(1)) else $error("inc value wrong");
    a_dec_value: assert property (@(posedge CLOCK) disable iff (!RST_N)
        IN_VALID && !IN_SIMD && IN_OP == incfind_pkg::OP_DEC
        |=> OUT_RESULT == $past(IN_A) - RW'(1)) else $error("dec value wrong");
    a_abs_value: assert property (@(posedge CLOCK) disable iff (!RST_N)
        IN_VALID && !IN_SIMD && IN_OP == incfind_pkg::OP_ABS
        |=> OUT_RESULT[RW-1] == 1'b0 || $past(IN_A) == {1'b1, {(RW-1){1'b0}}})
        else $error("abs sign wrong");
    a_min_value: assert property (@(posedge CLOCK) disable iff (!RST_N)
        IN_VALID && !IN_SIMD && !IN_SIGNED && IN_OP == incfind_pkg::OP_MIN
        |-> ##2 OUT_RESULT == (($past(IN_A, 2) < $past(IN_B, 2)) ? $past(IN_A, 2) : $past(IN_B, 2)))
        else $error("min value wrong");
    a_cmp_signed: assert property (@(posedge CLOCK) disable iff (!RST_N)
        IN_VALID && !IN_SIMD && IN_SIGNED && IN_OP == incfind_pkg::OP_CMP
        |-> ##2 OUT_RESULT[0] == ($signed($past(IN_A, 2)) > $signed($past(IN_B, 2))))
        else $error("signed compare wrong");
    a_lowset_value: assert property (@(posedge CLOCK) disable iff (!RST_N)
        IN_VALID && !IN_SIMD && IN_OP == incfind_pkg::OP_LOWEST_SET && IN_A != '0
        |-> ##2 ($past(IN_A, 2) & (RW'(1) << OUT_RESULT[6:0])) != '0)
        else $error("lowest set wrong");
endmodule // incfind_unit
`default_nettype wire

/* crossbar_model.sv */
// operand crossbar model that feeds the increment / find-bit unit
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/1ns
`default_nettype none
module crossbar_model #(
    parameter int unsigned RW = 64
) (
    output var logic valid,          // operands present
    output var logic [3:0] op,       // operation code
    output var logic simd,           // per chunk mode
    output var logic sgn,            // signed compare
    output var logic [RW-1:0] opnd_a, // first operand
    output var logic [RW-1:0] opnd_b  // second operand
);
    initial begin
        valid = 1'b0;
        op = 4'h0;
        simd = 1'b0;
        sgn = 1'b0;
        opnd_a = '0;
        opnd_b = '0;
    end
    task automatic drive(input logic [3:0] o, input logic s, input logic g,
                         input logic [RW-1:0] a, input logic [RW-1:0] b);
        valid = 1'b1;
        op = o;
        simd = s;
        sgn = g;
        opnd_a = a;
        opnd_b = b;
    endtask
    // released operands must not keep their last value
    task automatic idle();
        valid = 1'b0;
        opnd_a = ~opnd_a;
        opnd_b = ~opnd_b;
    endtask
endmodule // crossbar_model
`default_nettype wire

/* test_increment_find_bit_unit.sv */
// self-checking bench for the increment / find-bit unit
// assumes crossbar_model drives the operands and one op is issued at a time
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, e, g) \
    num_checks++; \
    if ((g) !== (e)) begin \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
        failures++; \
    end
module test_increment_find_bit_unit;
    localparam int unsigned RW = 64;
    localparam int unsigned CW = 8;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    wire logic in_valid;
    wire logic [3:0] in_op;
    wire logic in_simd;
    wire logic in_signed;
    wire logic [RW-1:0] in_a;
    wire logic [RW-1:0] in_b;
    logic out_valid;
    logic [RW-1:0] out_result;
    int failures = 0;
    int num_checks = 0;
    always #2 clock = ~clock;
    crossbar_model #(.RW(RW)) partner_u (.valid(in_valid), .op(in_op), .simd(in_simd),
        .sgn(in_signed), .opnd_a(in_a), .opnd_b(in_b));
    incfind_unit #(.RW(RW), .CW(CW)) dut_u (.CLOCK(clock), .RST_N(rst_n),
        .IN_VALID(in_valid), .IN_OP(in_op), .IN_SIMD(in_simd), .IN_SIGNED(in_signed),
        .IN_A(in_a), .IN_B(in_b), .OUT_VALID(out_valid), .OUT_RESULT(out_result));
    function automatic logic [63:0] ref_chunk(logic [3:0] op, logic sg,
                                              logic [63:0] a, logic [63:0] b, int w);
        logic [63:0] m;
        logic [63:0] x;
        logic [63:0] y;
        logic [63:0] r;
        m = (w == 64) ? '1 : ((64'h1 << w) - 64'h1);
        x = (a & m) ^ (sg ? (64'h1 << (w - 1)) : 64'h0);
        y = (b & m) ^ (sg ? (64'h1 << (w - 1)) : 64'h0);
        r = '0;
        case (op)
            incfind_pkg::OP_INC: r = a + 64'h1;
            incfind_pkg::OP_DEC: r = a - 64'h1;
            incfind_pkg::OP_NEG: r = 64'h0 - a;
            incfind_pkg::OP_ABS: r = a[w-1] ? 64'h0 - a : a;
            incfind_pkg::OP_LOWEST_SET: for (int i = w - 1; i >= 0; i--) if (a[i]) r = 64'(i);
            incfind_pkg::OP_LOWEST_CLEAR: for (int i = w - 1; i >= 0; i--) if (!a[i]) r = 64'(i);
            incfind_pkg::OP_HIGHEST_SET: for (int i = 0; i < w; i++) if (a[i]) r = 64'(i);
            incfind_pkg::OP_HIGHEST_CLEAR: for (int i = 0; i < w; i++) if (!a[i]) r = 64'(i);
            incfind_pkg::OP_MAX: r = (x > y) ? a : b;
            incfind_pkg::OP_CMP: r = (x > y) ? m : 64'h0;
            default: r = (x > y) ? b : a;
        endcase
        return r & m;
    endfunction
    function automatic logic [RW-1:0] ref_word(logic [3:0] op, logic s, logic g,
                                               logic [RW-1:0] a, logic [RW-1:0] b);
        logic [RW-1:0] r;
        logic [63:0] t;
        if (!s) return ref_chunk(op, g, a, b, RW);
        for (int c = 0; c < RW / CW; c++) begin
            t = ref_chunk(op, g, 64'(a[c*CW +: CW]), 64'(b[c*CW +: CW]), CW);
            r[c*CW +: CW] = t[CW-1:0];
        end
        return r;
    endfunction
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic run(input logic [3:0] op, input logic s, input logic g,
                       input logic [RW-1:0] a, input logic [RW-1:0] b, input int lat);
        int n;
        @(negedge clock);
        partner_u.drive(op, s, g, a, b);
        @(negedge clock);
        partner_u.idle();
        // n counts clocks since the taking edge
        n = 1;
        while (out_valid !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        if (out_valid !== 1'b1) begin
            failures++;
            wrap_up();
        end else begin
            `CHECK("latency", lat, n)
            `CHECK("result", ref_word(op, s, g, a, b), out_result)
            @(negedge clock);
            `CHECK("valid pulse", 1'b0, out_valid)
        end
    endtask
    task automatic t_reset();
        repeat (3) @(negedge clock);
        `CHECK("reset valid", 1'b0, out_valid)
        `CHECK("reset result", {RW{1'b0}}, out_result)
        rst_n = 1'b1;
    endtask
    task automatic t_inc_dec();
        run(incfind_pkg::OP_INC, 1'b0, 1'b0, 64'h0000_0000_0000_00ff, '0, 1);
        run(incfind_pkg::OP_INC, 1'b0, 1'b0, 64'hffff_ffff_ffff_ffff, '0, 1);
        run(incfind_pkg::OP_DEC, 1'b0, 1'b0, 64'h0000_0001_0000_0000, '0, 1);
        run(incfind_pkg::OP_DEC, 1'b0, 1'b0, 64'h0000_0000_0000_0000, '0, 1);
    endtask
    task automatic t_neg_abs();
        run(incfind_pkg::OP_NEG, 1'b0, 1'b0, 64'h0000_0000_0000_0005, '0, 1);
        run(incfind_pkg::OP_ABS, 1'b0, 1'b0, 64'hffff_ffff_ffff_fffb, '0, 1);
        run(incfind_pkg::OP_ABS, 1'b0, 1'b0, 64'h7fff_ffff_ffff_fffb, '0, 1);
    endtask
    task automatic t_find();
        for (int i = 4; i < 8; i++) begin
            run(4'(i), 1'b0, 1'b0, 64'hf0f0_0000_0000_0f0b, '0, 2);
            run(4'(i), 1'b0, 1'b0, 64'h0010_0000_0000_0100, '0, 2);
        end
    endtask
    task automatic t_compare();
        for (int i = 8; i < 12; i++) begin
            for (int g = 0; g < 2; g++) begin
                run(4'(i), 1'(g), 1'(g), 64'h0000_0000_0000_0005, 64'h0000_0000_0000_0009,
                    2);
                run(4'(i), 1'b0, 1'(g), 64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0001,
                    2);
                run(4'(i), 1'b0, 1'(g), 64'h1234_0000_0000_0000, 64'h1234_0000_0000_0000,
                    2);
            end
        end
    endtask
    task automatic t_simd();
        run(incfind_pkg::OP_INC, 1'b1, 1'b0, 64'h00ff_7f00_ff01_80fe, '0, 1);
        run(incfind_pkg::OP_DEC, 1'b1, 1'b0, 64'h00ff_7f00_ff01_80fe, '0, 1);
        run(incfind_pkg::OP_ABS, 1'b1, 1'b0, 64'h00ff_7f00_ff01_80fe, '0, 1);
        run(incfind_pkg::OP_NEG, 1'b1, 1'b0, 64'h00ff_7f00_ff01_80fe, '0, 1);
        run(incfind_pkg::OP_HIGHEST_SET, 1'b1, 1'b0, 64'h0180_0001_4020_1008, '0,
            2);
    endtask
    task automatic t_back_to_back();
        @(negedge clock);
        partner_u.drive(incfind_pkg::OP_INC, 1'b0, 1'b0, 64'h0000_0000_0000_0003, '0);
        @(negedge clock);
        `CHECK("first valid", 1'b1, out_valid)
        `CHECK("first result", 64'h0000_0000_0000_0004, out_result)
        partner_u.drive(incfind_pkg::OP_DEC, 1'b0, 1'b0, 64'h0000_0000_0000_0003, '0);
        @(negedge clock);
        partner_u.idle();
        `CHECK("second valid", 1'b1, out_valid)
        `CHECK("second result", 64'h0000_0000_0000_0002, out_result)
    endtask
    initial begin
        t_reset();
        t_inc_dec();
        t_neg_abs();
        t_find();
        t_compare();
        t_simd();
        t_back_to_back();
        wrap_up();
    end
endmodule // test_increment_find_bit_unit
`default_nettype wire
